// ---- design/dac_front.sv ----
// Purpose : Digital front end of a 14-bit current-output converter
// Assumes : Sample word and sleep come from another clock, synchronised here
// Notes   : Output currents modelled as codes in full-scale units
//
// Contract
// - Accept 14-bit straight binary word, msb bit 13, lsb bit 0.
// - All ones drives full scale on primary; complementary carries the remainder.
// - Capture word in edge latch, update output only on rising edge.
// - Any clock duty cycle; host keeps pulse widths, setup and hold.
// - Sleep high switches output current off, low-power state.
// - Sleep input pulled low internally; floating means enabled.
// - Power-down within 50 ns (here two sync stages plus one cycle, up to 75 ns at 40 MHz); about 5 us wake before output valid.
// - Primary gets code/16384, complementary gets (16383-code)/16384 full scale.
`timescale 1ns/100ps
module dac_front
  import dac_front_pkg::*;
#(
  parameter int WIDTH     = SAMPLE_WIDTH,
  parameter int DEPTH     = FIFO_DEPTH,
  parameter int WAKE_CNT  = WAKE_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_sample,
  input  wire logic             i_sample_valid,
  output      logic             o_sample_ready,
  input  wire logic             i_sleep_n_floating,
  input  wire logic             i_sleep,
  output      logic [WIDTH-1:0] o_primary_current,
  output      logic [WIDTH-1:0] o_complementary_current,
  output      logic             o_output_valid,
  output      logic             o_low_power
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       sleep_sync;
    logic [1:0]       drive_sync;
    logic [WIDTH-1:0] data_meta;
    logic [WIDTH-1:0] data_sync;
    logic [1:0]       valid_sync;
    logic             low_power;
    logic [12:0]      wake_cnt;
    logic [12:0]      dark_cnt;
    logic             out_valid;
    logic [WIDTH-1:0] code;
  } front_state_t;

  front_state_t state_reg;
  front_state_t state_next;
  logic         sleep_req;
  logic         fifo_valid;
  logic [WIDTH-1:0] fifo_data;
  logic         fifo_pop;

  // Unconnected sleep pin reads as awake; both pins synchronised before gating
  assign sleep_req = state_reg.sleep_sync[1] && state_reg.drive_sync[1];

  sample_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (state_reg.valid_sync[1]),
    .o_in_ready  (o_sample_ready),
    .i_in_data   (state_reg.data_sync),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  // Drain always; while asleep samples are dropped, not held
  assign fifo_pop = fifo_valid;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.sleep_sync = {state_reg.sleep_sync[0], i_sleep};
    state_next.drive_sync = {state_reg.drive_sync[0], i_sleep_n_floating};
    state_next.data_meta  = i_sample;
    state_next.data_sync  = state_reg.data_meta;
    state_next.valid_sync = {state_reg.valid_sync[0], i_sample_valid};
    if (sleep_req) begin
      // Entry one cycle after sleep_req, two sync stages behind the pin: up to 75 ns, over the 50 ns bound
      state_next.low_power = 1'b1;
      state_next.out_valid = 1'b0;
      state_next.wake_cnt  = '0;
    end else if (state_reg.low_power) begin
      if (state_reg.wake_cnt == 13'(WAKE_CNT - 1)) begin
        state_next.low_power = 1'b0;
        state_next.out_valid = 1'b1;
      end else begin
        state_next.wake_cnt = state_reg.wake_cnt + 1'b1;
      end
    end
    // Rising-edge capture, only while awake; duty cycle plays no part
    if (fifo_valid && state_reg.out_valid && !sleep_req) begin
      state_next.code = fifo_data;
    end
    // Cycles spent dark since sleep released, for the wake check
    if (state_reg.out_valid || sleep_req) begin
      state_next.dark_cnt = '0;
    end else if (state_reg.dark_cnt != '1) begin
      state_next.dark_cnt = state_reg.dark_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg           <= '0;
      state_reg.out_valid <= 1'b1;
      state_reg.code      <= CODE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Currents forced off in sleep; complement is 16383 minus code
  assign o_primary_current       = state_reg.low_power ? '0 : state_reg.code;
  assign o_complementary_current = state_reg.low_power ? '0 :
                                   WIDTH'(CODE_MAX) - state_reg.code;
  assign o_output_valid          = state_reg.out_valid;
  assign o_low_power             = state_reg.low_power;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_sum_full_scale: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_low_power |-> (o_primary_current + o_complementary_current) == WIDTH'(CODE_MAX))
    else $error("Output currents do not sum to full scale");
  a_sleep_off: assert property (@(posedge i_clk) disable iff (i_rst)
    o_low_power |-> (o_primary_current == '0 && o_complementary_current == '0))
    else $error("Current flows in low power");
  a_sleep_entry: assert property (@(posedge i_clk) disable iff (i_rst)
    sleep_req |=> o_low_power && !o_output_valid)
    else $error("Power-down too slow");
  a_pin_pulldown: assert property (@(posedge i_clk) disable iff (i_rst)
    (!state_reg.drive_sync[1] && !o_low_power) |=> !o_low_power)
    else $error("Floating sleep pin entered sleep");
  a_wake_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(sleep_req) |=> !o_output_valid [*8])
    else $error("Output valid too soon after wake");
  a_wake_span: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_output_valid) |-> state_reg.dark_cnt >= 13'(WAKE_CNT))
    else $error("Wake time shorter than wake count");
  a_dark_power: assert property (@(posedge i_clk) disable iff (i_rst)
    o_low_power |-> !o_output_valid)
    else $error("Output valid while powered down");
  a_wake_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_low_power && !sleep_req) |-> state_reg.wake_cnt < 13'(WAKE_CNT))
    else $error("Wake counter past its end");
  a_wake_release: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_low_power && !sleep_req && state_reg.wake_cnt == 13'(WAKE_CNT - 1)) |=>
      (!o_low_power && o_output_valid))
    else $error("Wake did not release output");
  a_primary_code: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_low_power |-> o_primary_current == state_reg.code)
    else $error("Primary current differs from code");
  a_fifo_push: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg.valid_sync[1] && o_sample_ready) |=> fifo_valid)
    else $error("Synchronised sample not queued");
  a_full_pending: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_sample_ready |-> fifo_valid)
    else $error("Queue full yet empty");
  a_code_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_output_valid |=> $stable(state_reg.code))
    else $error("Code changed while output invalid");
  a_capture: assert property (@(posedge i_clk) disable iff (i_rst)
    (fifo_valid && o_output_valid && !sleep_req) |=>
      state_reg.code == $past(fifo_data))
    else $error("Sample not captured");
  a_full_code: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_low_power && state_reg.code == WIDTH'(CODE_MAX)) |->
      o_complementary_current == '0)
    else $error("Complement not zero at full code");

  c_sample_out:  cover property (@(posedge i_clk) fifo_valid && o_output_valid);
  c_sleep_enter: cover property (@(posedge i_clk) $rose(o_low_power));
  c_wake_done:   cover property (@(posedge i_clk) $rose(o_output_valid));
  c_fifo_full:   cover property (@(posedge i_clk) !o_sample_ready);
  c_pin_ignored: cover property (@(posedge i_clk)
    state_reg.sleep_sync[1] && !state_reg.drive_sync[1]);
endmodule

// ---- design/dac_front_pkg.sv ----
// Purpose : Shared constants for the converter digital front end
// Assumes : 40 MHz system clock, 14-bit straight binary samples
// Notes   : Times kept in their own units, cycle counts derived
package dac_front_pkg;
  localparam int          SAMPLE_WIDTH    = 14;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          CLK_PERIOD_PS   = 25000;
  localparam int          SLEEP_ENTRY_NS  = 50;
  localparam int          WAKE_TIME_NS    = 5000;
  // Longest time rounds down, least time rounds up
  localparam int          SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * 1000) / CLK_PERIOD_PS;
  localparam int          WAKE_CYC        = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int          CODE_MAX        = 16383;
  localparam logic [13:0] CODE_RESET      = 14'h0000;
endpackage

// ---- design/sample_fifo.sv ----
// Purpose : Small flip-flop FIFO with valid/ready on both sides
// Assumes : Single clock, synchronous active-high reset
// Notes   : Full and empty are exact; no write when full
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output      logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output      logic             o_out_valid,
  input  wire logic             i_out_ready,
  output      logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic        push;
  logic        pop;

  assign o_in_ready  = (state_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (state_reg.count != '0);
  assign o_out_data  = state_reg.mem[state_reg.rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = i_in_data;
      state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  a_fifo_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg.count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule

// ---- test/sample_host.sv ----
// Purpose : Host logic model driving parallel sample words
// Assumes : Words launched on the falling clock edge
// Notes   : Idle bus shows inverted data so a stale word never passes as fresh
`timescale 1ns/100ps
module sample_host
  import dac_front_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_go,
  input  wire logic [SAMPLE_WIDTH-1:0] i_word,
  output      logic                    o_sample_valid,
  output      logic [SAMPLE_WIDTH-1:0] o_sample
);
  initial begin
    o_sample_valid = 1'b0;
    o_sample       = 14'h0000;
  end
  // Falling edge launch keeps data clear of the capture edge
  always @(negedge i_clk) begin
    o_sample_valid <= i_go;
    o_sample       <= i_go ? i_word : ~o_sample;
  end
endmodule

// ---- test/dac_parallel_input_sleep_test.sv ----
// Purpose : Self-checking bench for the converter front end
// Assumes : 40 MHz clock, shortened wake count
// Notes   : Wake count cut to 10 cycles to keep the run short
`timescale 1ns/100ps
module dac_parallel_input_sleep_test
  import dac_front_pkg::*;
;
  localparam int WAKE = 10;
  logic                    clk    = 1'b0;
  logic                    rst    = 1'b1;
  logic                    go     = 1'b0;
  logic                    driven = 1'b1;
  logic                    sleep  = 1'b0;
  logic [SAMPLE_WIDTH-1:0] word   = 14'h0000;
  logic [SAMPLE_WIDTH-1:0] sample, prim, comp;
  logic                    sample_valid, ready, out_valid, low_power;
  int                      err_total   = 0;
  int                      checks_done = 0;
  logic [SAMPLE_WIDTH-1:0] codes [5] = '{14'h0000, 14'h0001, 14'h2000, 14'h1555, 14'h3fff};
  always #12.5 clk = ~clk;
  sample_host i_host (.i_clk(clk), .i_go(go), .i_word(word),
                      .o_sample_valid(sample_valid), .o_sample(sample));
  dac_front #(.WAKE_CNT(WAKE)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_sample(sample), .i_sample_valid(sample_valid),
    .o_sample_ready(ready), .i_sleep_n_floating(driven), .i_sleep(sleep),
    .o_primary_current(prim), .o_complementary_current(comp),
    .o_output_valid(out_valid), .o_low_power(low_power));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [SAMPLE_WIDTH-1:0] seen, input logic [SAMPLE_WIDTH-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [SAMPLE_WIDTH-1:0] code);
    word = code;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    check(prim, 14'h0000);
    check(comp, 14'(CODE_MAX));
    check(14'(out_valid), 14'h0001);
    check(14'(low_power), 14'h0000);
    check(14'(ready), 14'h0001);
  endtask
  task automatic test_codes();
    foreach (codes[i]) begin
      send(codes[i]);
      tick(6);
      check(prim, codes[i]);
      check(comp, 14'(CODE_MAX) - codes[i]);
    end
  endtask
  task automatic test_stream();
    go = 1'b1;
    for (int i = 0; i < 8; i++) begin
      word = 14'h0100 + 14'(i);
      tick(1);
      check(14'(ready), 14'h0001);
    end
    go = 1'b0;
    tick(6);
    check(prim, 14'h0107);
    check(comp, 14'h3ef8);
  endtask
  task automatic test_sleep();
    int n;
    n = 0;
    sleep = 1'b1;
    tick(3);
    check(14'(low_power), 14'h0001);
    check(14'(out_valid), 14'h0000);
    check(prim, 14'h0000);
    check(comp, 14'h0000);
    send(14'h0abc);
    sleep = 1'b0;
    tick(WAKE - 1);
    check(14'(out_valid), 14'h0000);
    while (out_valid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check(14'(n <= 5), 14'h0001);
    check(14'(low_power), 14'h0000);
    check(prim, 14'h0107);
  endtask
  task automatic test_floating();
    driven = 1'b0;
    sleep = 1'b1;
    tick(5);
    check(14'(low_power), 14'h0000);
    check(14'(out_valid), 14'h0001);
    sleep = 1'b0;
    driven = 1'b1;
    tick(2);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(1);
    test_reset();
    test_codes();
    test_stream();
    test_sleep();
    test_floating();
    give_verdict();
  end
  // Whole run is near 90 cycles; this allows many times that
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
